// [inc/fspc_defines.svh]
// register map, field positions, reset values and timing of the flash sequencer
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH
// register indices, byte address is four times the index
`define FSPC_CTRL_IDX 10'h037
`define FSPC_CFG_IDX 10'h038
`define FSPC_STAT_IDX 10'h039
// reset values
`define FSPC_CTRL_RST 8'h00
`define FSPC_CFG_RST 2'h0
`define FSPC_LOCK_RST 6'h3f
// control and status bit positions
`define FSPC_B_IE 7
`define FSPC_B_BUSY 6
`define FSPC_B_SIG 5
`define FSPC_B_EN 0
`define FSPC_B_APPLK 2
// accepted patterns of the lower five control bits
`define FSPC_PAT_REEN 5'h11
`define FSPC_PAT_BLB 5'h09
`define FSPC_PAT_PGW 5'h05
`define FSPC_PAT_PGE 5'h03
`define FSPC_PAT_FILL 5'h01
// arming windows in clocks
`define FSPC_STORE_WIN 3'h4
`define FSPC_LOAD_WIN 3'h3
// boot section start words per boot size fuse code
`define FSPC_BOOT_512 17'h1fe00
`define FSPC_BOOT_1K 17'h1fc00
`define FSPC_BOOT_2K 17'h1f800
`define FSPC_BOOT_4K 17'h1f000
// first word and first page of the non-concurrent section
`define FSPC_HIGH_START 17'h1f000
`define FSPC_HIGH_PAGE 10'h3e0
// timing
`define FSPC_CLK_NS 8
`define FSPC_ERASE_NS 4000
`define FSPC_WRITE_NS 4000
`endif

// [inc/fspc_pkg.sv]
// types shared by the flash sequencer files
package fspc_pkg;
   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARMED,
      ST_BUSY
   } fspc_state_e;
   // one instruction from the core
   typedef struct packed {
      logic store;
      logic load;
      logic [15:0] ptr;
      logic [7:0] ext_page;
      logic [15:0] data;
   } fspc_cpu_req_s;
   // answer to the core
   typedef struct packed {
      logic hold;
      logic ld_valid;
      logic [7:0] ld_data;
   } fspc_cpu_rsp_s;
   // command towards the flash array
   typedef struct packed {
      logic erase;
      logic write;
      logic [9:0] page;
   } fspc_flash_cmd_s;
   // whole state of the top module
   typedef struct packed {
      fspc_state_e st;
      logic [7:0] ctrl;
      logic [2:0] st_win;
      logic [2:0] ld_win;
      logic [1:0] boot_size;
      logic [5:0] lock;
      logic halt;
      logic is_write;
      logic [127:0] mask;
      logic buf_hit;
      logic aw_got;
      logic w_got;
      logic [11:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [7:0] ld_data;
      logic ld_valid;
      fspc_flash_cmd_s fcmd;
   } fspc_regs_s;
endpackage

// [rtl/fspc_op_timer.sv]
// countdown that holds busy for one cycle more than the programmed number of cycles
`timescale 1ns/1ps
`default_nettype none
module fspc_op_timer #(
   parameter int CW = 16
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // start with a cycle count of at least one
   input wire logic start_i,
   input wire logic [CW-1:0] cycles_i,
   // status
   output logic busy_o,
   output logic done_o
);
   logic [CW-1:0] cnt_q; // cycles left
   logic [CW-1:0] cnt_d;
   logic done_q; // one-cycle end pulse
   logic done_d;

   ////////////////////////////////////////////////////////////////////////
   // next count
   always_comb begin
      cnt_d = cnt_q;
      done_d = 1'b0;
      if (start_i) begin
         cnt_d = cycles_i;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - 1'b1;
         done_d = (cnt_q == {{(CW-1){1'b0}}, 1'b1});
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= '0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         done_q <= done_d;
      end
   end

   assign busy_o = (cnt_q != '0) | done_q;
   assign done_o = done_q;
endmodule
`default_nettype wire

// [rtl/fspc_page_buf.sv]
// temporary page buffer, one write port and one registered read port
`timescale 1ns/1ps
`default_nettype none
module fspc_page_buf #(
   parameter int DW = 16,
   parameter int AW = 7
) (
   // clock
   input wire logic sys_clk_i,
   // fill port
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [DW-1:0] wdata_i,
   // read port
   input wire logic [AW-1:0] raddr_i,
   output logic [DW-1:0] rdata_o
);
   // storage, no reset: validity is tracked by the owner
   logic [DW-1:0] mem_q [0:(1<<AW)-1];

   ////////////////////////////////////////////////////////////////////////
   // write and registered read
   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= mem_q[raddr_i];
   end
endmodule
`default_nettype wire

// [rtl/fspc_top.sv]
// self-programming sequencer for program flash with axi4-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.svh"

module fspc_top
   import fspc_pkg::*;
#(
   parameter int ERASE_CYCLES = `FSPC_ERASE_NS / `FSPC_CLK_NS,
   parameter int WRITE_CYCLES = `FSPC_WRITE_NS / `FSPC_CLK_NS,
   // signature row contents, value is arbitrary
   parameter logic [23:0] SIGNATURE = 24'h5a3c96
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // axi4-lite write channels
   input wire logic [11:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // axi4-lite read channels
   input wire logic [11:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   // core side
   input wire fspc_cpu_req_s cpu_req_i,
   input wire logic irq_global_i,
   output fspc_cpu_rsp_s cpu_rsp_o,
   output logic prog_ready_irq_o,
   output logic section_blocked_o,
   // flash array side
   output fspc_flash_cmd_s flash_cmd_o,
   input wire logic [6:0] flash_buf_addr_i,
   output logic [15:0] flash_buf_data_o
);
   localparam int TCW = 16; // timer width
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   fspc_regs_s q; // all state
   fspc_regs_s d; // next state
   logic [17:0] ptr18; // extended byte pointer
   logic [9:0] page; // page index
   logic [6:0] word; // word in page
   logic buf_we; // buffer fill strobe
   logic tmr_start; // start erase or write
   logic [TCW-1:0] tmr_cycles; // duration of that operation
   logic tmr_busy; // operation running
   logic tmr_done; // operation finished
   logic [15:0] buf_rdata; // buffer word for the flash
   logic [9:0] widx; // write register index
   logic [9:0] ridx; // read register index
   logic [4:0] wpat; // written lower five bits

   ////////////////////////////////////////////////////////////////////////
   // helper functions

   // first word of the boot section
   function automatic logic [16:0] boot_start(input logic [1:0] sz);
      logic [16:0] s;
      s = `FSPC_BOOT_4K;
      case (sz)
         2'h3: s = `FSPC_BOOT_512;
         2'h2: s = `FSPC_BOOT_1K;
         2'h1: s = `FSPC_BOOT_2K;
         default: s = `FSPC_BOOT_4K;
      endcase
      return s;
   endfunction

   // accepted lower five bit pattern
   function automatic logic pat_ok(input logic [4:0] p);
      return (p == `FSPC_PAT_REEN) || (p == `FSPC_PAT_BLB) ||
             (p == `FSPC_PAT_PGW) || (p == `FSPC_PAT_PGE) ||
             (p == `FSPC_PAT_FILL);
   endfunction

   // word index of a byte address on the bus
   function automatic logic [9:0] reg_idx(input logic [11:0] a);
      return a[11:2];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // pointer mapping
   // top pointer bits
   assign ptr18 = {cpu_req_i.ext_page[1:0], cpu_req_i.ptr};
   // page and word split, bit zero unused for stores
   assign page = ptr18[17:8];
   assign word = ptr18[7:1];
   assign widx = reg_idx(q.awaddr);
   assign ridx = reg_idx(araddr_i);
   assign wpat = q.wdata[4:0];

   ////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      d.fcmd = '0;
      d.ld_valid = 1'b0;
      buf_we = 1'b0;
      tmr_start = 1'b0;
      tmr_cycles = TCW'(ERASE_CYCLES);
      // flash side validity of the word it reads
      d.buf_hit = q.mask[flash_buf_addr_i];

      // sequencer
      case (q.st)
         ST_ARMED: begin
            // windows count down from the write
            if (q.ld_win != 3'h0) begin
               d.ld_win = q.ld_win - 3'h1;
            end
            d.st_win = q.st_win - 3'h1;
            if (q.st_win == 3'h1) begin
               d.ctrl[5:0] = 6'h00;
               d.st = ST_IDLE;
            end
            if (cpu_req_i.load && q.ld_win != 3'h0) begin
               if (q.ctrl[`FSPC_B_SIG]) begin
                  d.ld_valid = 1'b1;
                  d.ld_data = SIGNATURE[8*ptr18[2:1] +: 8];
                  d.ctrl[5:0] = 6'h00;
                  d.st = ST_IDLE;
               end else if (q.ctrl[4:0] == `FSPC_PAT_BLB) begin
                  // lock or fuse by bit zero
                  d.ld_valid = 1'b1;
                  d.ld_data = ptr18[0] ? {6'h3f, q.boot_size}
                                       : {2'h3, q.lock};
                  d.ctrl[5:0] = 6'h00;
                  d.st = ST_IDLE;
               end
            end
            if (cpu_req_i.store) begin
               d.ctrl[5:0] = 6'h00;
               d.st = ST_IDLE;
               if (q.ctrl[`FSPC_B_SIG]) begin
                  // store after signature arm is void
                  d.st = ST_IDLE;
               end else begin
                  case (q.ctrl[4:0])
                     `FSPC_PAT_FILL: begin
                        buf_we = 1'b1;
                        d.mask[word] = 1'b1;
                        d.ctrl[`FSPC_B_BUSY] = 1'b0;
                     end
                     `FSPC_PAT_PGE, `FSPC_PAT_PGW: begin
                        if (!q.lock[`FSPC_B_APPLK] &&
                            {page, 7'h00} < boot_start(q.boot_size)) begin
                           d.st = ST_IDLE;
                        end else begin
                           d.is_write = (q.ctrl[4:0] == `FSPC_PAT_PGW);
                           d.fcmd.erase = ~d.is_write;
                           d.fcmd.write = d.is_write;
                           d.fcmd.page = page;
                           tmr_start = 1'b1;
                           if (d.is_write) begin
                              tmr_cycles = TCW'(WRITE_CYCLES);
                           end
                           // keep enable and command while busy
                           d.ctrl[4:0] = q.ctrl[4:0];
                           d.st = ST_BUSY;
                           if (page >= `FSPC_HIGH_PAGE) begin
                              d.halt = 1'b1;
                           end else begin
                              d.ctrl[`FSPC_B_BUSY] = 1'b1;
                           end
                        end
                     end
                     `FSPC_PAT_BLB: begin
                        // program boot lock bits from low data
                        d.lock[5:2] = q.lock[5:2] & cpu_req_i.data[5:2];
                     end
                     `FSPC_PAT_REEN: begin
                        d.ctrl[`FSPC_B_BUSY] = 1'b0;
                     end
                     default: begin
                        d.st = ST_IDLE;
                     end
                  endcase
               end
            end
         end
         ST_BUSY: begin
            if (tmr_done) begin
               d.ctrl[5:0] = 6'h00;
               d.halt = 1'b0;
               d.st = ST_IDLE;
               if (q.is_write) begin
                  d.mask = '0;
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase

      // axi write address and data, either order
      if (awvalid_i && awready_o) begin
         d.aw_got = 1'b1;
         d.awaddr = awaddr_i;
      end
      if (wvalid_i && wready_o) begin
         d.w_got = 1'b1;
         d.wdata = wdata_i;
         d.wstrb = wstrb_i;
      end
      if (bvalid_o && bready_i) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_got && q.w_got) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         if (widx == `FSPC_CTRL_IDX) begin
            if (q.wstrb[0]) begin
               d.ctrl[`FSPC_B_IE] = q.wdata[`FSPC_B_IE];
               // only accepted patterns, none while busy
               if (pat_ok(wpat) && d.st != ST_BUSY &&
                   (!q.wdata[`FSPC_B_SIG] || wpat == `FSPC_PAT_FILL)) begin
                  d.ctrl[5:0] = q.wdata[5:0];
                  d.st = ST_ARMED;
                  d.st_win = `FSPC_STORE_WIN;
                  d.ld_win = `FSPC_LOAD_WIN;
                  if (wpat == `FSPC_PAT_REEN) begin
                     d.mask = '0;
                  end
               end
            end
         end else if (widx == `FSPC_CFG_IDX) begin
            if (q.wstrb[0]) begin
               d.boot_size = q.wdata[1:0];
            end
         end else if (widx != `FSPC_STAT_IDX) begin
            d.bresp = RESP_DECERR;
         end
      end

      // axi read
      if (rvalid_o && rready_i) begin
         d.rvalid = 1'b0;
      end
      if (arvalid_i && arready_o) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = 32'h0000_0000;
         if (ridx == `FSPC_CTRL_IDX) begin
            d.rdata[7:0] = q.ctrl;
         end else if (ridx == `FSPC_CFG_IDX) begin
            d.rdata[1:0] = q.boot_size;
         end else if (ridx == `FSPC_STAT_IDX) begin
            d.rdata[7:0] = {q.halt, tmr_busy, q.lock};
         end else begin
            d.rresp = RESP_DECERR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ctrl <= `FSPC_CTRL_RST;
         q.boot_size <= `FSPC_CFG_RST;
         q.lock <= `FSPC_LOCK_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page buffer and operation timer
   fspc_page_buf #(
      .DW(16),
      .AW(7)
   ) u_buf (
      .sys_clk_i(sys_clk_i),
      .we_i(buf_we),
      .waddr_i(word),
      .wdata_i(cpu_req_i.data),
      .raddr_i(flash_buf_addr_i),
      .rdata_o(buf_rdata)
   );

   fspc_op_timer #(
      .CW(TCW)
   ) u_tmr (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(tmr_start),
      .cycles_i(tmr_cycles),
      .busy_o(tmr_busy),
      .done_o(tmr_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign awready_o = ~q.aw_got & ~q.bvalid;
   assign wready_o = ~q.w_got & ~q.bvalid;
   assign bvalid_o = q.bvalid;
   assign bresp_o = q.bresp;
   assign arready_o = ~q.rvalid;
   assign rvalid_o = q.rvalid;
   assign rdata_o = q.rdata;
   assign rresp_o = q.rresp;
   // hold answer while the core is stopped
   assign cpu_rsp_o.hold = q.halt;
   assign cpu_rsp_o.ld_valid = q.ld_valid;
   assign cpu_rsp_o.ld_data = q.ld_data;
   assign prog_ready_irq_o = q.ctrl[`FSPC_B_IE] & irq_global_i &
                             ~q.ctrl[`FSPC_B_EN];
   assign section_blocked_o = q.ctrl[`FSPC_B_BUSY];
   assign flash_cmd_o = q.fcmd;
   // unloaded buffer words read as erased
   assign flash_buf_data_o = q.buf_hit ? buf_rdata : 16'hffff;
endmodule
`default_nettype wire

// [tb/fspc_cpu_model.sv]
// core model issuing store and load program instructions
`timescale 1ns/1ps
`default_nettype none
module fspc_cpu_model
   import fspc_pkg::*;
(
   // clock
   input wire logic sys_clk_i,
   // instruction out, answer in
   output fspc_cpu_req_s cpu_req_o,
   input wire fspc_cpu_rsp_s cpu_rsp_i
);
   initial cpu_req_o = '0;
   ////////////////////////////////////////////////////////////////////////
   // one-cycle request
   task automatic issue(input logic st, input logic [17:0] p,
                        input logic [15:0] d);
      @(posedge sys_clk_i);
      cpu_req_o <= {st, ~st, p[15:0], 6'h00, p[17:16], d};
      @(posedge sys_clk_i);
      // released strobes drop low, the other lines show the inverse of the last value
      cpu_req_o <= {2'b00, ~p[15:0], 6'h3f, ~p[17:16], ~d};
   endtask
   // load and wait for the byte
   task automatic load(input logic [17:0] p, output logic [8:0] res);
      int n;
      res = 9'h000;
      issue(1'b0, p, 16'h0000);
      for (n = 0; n < 4 && res[8] !== 1'b1; n++) begin
         @(posedge sys_clk_i);
         if (cpu_rsp_i.ld_valid === 1'b1) begin
            res = {1'b1, cpu_rsp_i.ld_data};
         end
      end
   endtask
endmodule
`default_nettype wire

// [tb/fspc_top_properties.sv]
// assertions on the ports of the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module fspc_top_properties
   import fspc_pkg::*;
#(
   parameter int ERASE_CYCLES = 500,
   parameter int WRITE_CYCLES = 500
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // register bus answers
   input wire logic [1:0] bresp_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [31:0] rdata_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   // core and flash side
   input wire fspc_cpu_req_s cpu_req_i,
   input wire logic irq_global_i,
   input wire fspc_cpu_rsp_s cpu_rsp_o,
   input wire logic prog_ready_irq_o,
   input wire logic section_blocked_o,
   input wire fspc_flash_cmd_s flash_cmd_o
);
   // shortest and longest legal halt
   localparam int MIN_C = (ERASE_CYCLES < WRITE_CYCLES) ?
      ERASE_CYCLES : WRITE_CYCLES;
   localparam int MAX_C = ERASE_CYCLES + WRITE_CYCLES + 4;
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic op_w; // any flash operation pulse
   logic [15:0] hold_q; // cycles the core has been held
   logic [15:0] hold_d;
   assign op_w = flash_cmd_o.erase | flash_cmd_o.write;
   ////////////////////////////////////////////////////////////////////////
   // count consecutive held cycles
   always_comb begin
      hold_d = cpu_rsp_o.hold ? hold_q + 16'h0001 : 16'h0000;
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         hold_q <= 16'h0000;
      end else begin
         hold_q <= hold_d;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // irq needs global flag
   irq_gate_a: assert property (
      prog_ready_irq_o |-> irq_global_i) else $error("irq without flag");
   op_cause_a: assert property (
      op_w |-> $past(cpu_req_i.store)) else $error("op without store");
   op_pulse_a: assert property (
      op_w |=> !op_w) else $error("flash command longer than one cycle");
   busy_set_a: assert property (
      op_w && flash_cmd_o.page < 10'h3e0 |-> ##[0:1] section_blocked_o)
      else $error("busy flag not set");
   core_halt_a: assert property (
      op_w && flash_cmd_o.page >= 10'h3e0 |-> ##[0:1] cpu_rsp_o.hold)
      else $error("core not halted");
   halt_min_a: assert property (
      $fell(cpu_rsp_o.hold) |-> hold_q >= 16'(MIN_C))
      else $error("halt too short");
   halt_max_a: assert property (
      cpu_rsp_o.hold |-> hold_q <= 16'(MAX_C)) else $error("halt too long");
   load_answer_a: assert property (
      cpu_rsp_o.ld_valid |-> $past(cpu_req_i.load))
      else $error("load answer without load");
   busy_clear_a: assert property (
      $fell(section_blocked_o) |->
      $past(cpu_req_i.store) || $past(cpu_req_i.store, 2))
      else $error("busy flag cleared without store");
   // write answer stands
   wresp_hold_a: assert property (
      bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
      else $error("write answer dropped");
   // read answer stands
   rdata_hold_a: assert property (
      rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
      else $error("read answer dropped");
endmodule
`default_nettype wire

// [tb/tb_fspc_top.sv]
// bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fspc_defines.svh"
module tb_fspc_top
   import fspc_pkg::*;
;
   localparam logic [11:0] A_CTRL = {`FSPC_CTRL_IDX, 2'b00};
   localparam logic [11:0] A_CFG = {`FSPC_CFG_IDX, 2'b00};
   localparam logic [11:0] A_STAT = {`FSPC_STAT_IDX, 2'b00};
   // bench drives
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic irq_g = 1'b0;
   logic [6:0] buf_addr = 7'h00;
   // design answers
   logic awready, wready, bvalid, arready, rvalid, irq, blocked;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] buf_data;
   fspc_cpu_req_s cpu_req;
   fspc_cpu_rsp_s cpu_rsp;
   fspc_flash_cmd_s fcmd, last_cmd;
   int op_count = 0;
   int fail_count = 0;
   int samples_checked = 0;
   always #4 sys_clk_i = ~sys_clk_i;
   ////////////////////////////////////////////////////////////////////////
   fspc_top #(.ERASE_CYCLES(20), .WRITE_CYCLES(20),
      .SIGNATURE(24'h5a3c96)) u_fspc_top (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb),
      .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp),
      .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
      .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata),
      .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
      .cpu_req_i(cpu_req), .irq_global_i(irq_g), .cpu_rsp_o(cpu_rsp),
      .prog_ready_irq_o(irq), .section_blocked_o(blocked),
      .flash_cmd_o(fcmd), .flash_buf_addr_i(buf_addr),
      .flash_buf_data_o(buf_data));
   fspc_cpu_model u_fspc_cpu_model (.sys_clk_i(sys_clk_i),
      .cpu_req_o(cpu_req), .cpu_rsp_i(cpu_rsp));
   // record flash commands
   always @(posedge sys_clk_i) begin
      if (fcmd.erase || fcmd.write) begin
         op_count <= op_count + 1;
         last_cmd <= fcmd;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // one register write, payload held until taken
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge sys_clk_i);
      r = 2'b01;
      n = 0;
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (r === 2'b01 && n < 40) begin
         @(posedge sys_clk_i);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
         end
      end
      if (n >= 40) begin
         fail_count++;
         close_out();
      end
   endtask
   // one register read
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      int n;
      @(posedge sys_clk_i);
      n = 0;
      r = 2'b01;
      d = 32'h0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (r === 2'b01 && n < 40) begin
         @(posedge sys_clk_i);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
         end
      end
      if (n >= 40) begin
         fail_count++;
         close_out();
      end
   endtask
   // read a buffer word from the flash side
   task automatic buf_chk(input logic [6:0] a, input logic [15:0] e);
      buf_addr <= a;
      repeat (2) @(posedge sys_clk_i);
      chk(buf_data, e);
   endtask
   // poll until the enable bit has cleared
   task automatic wait_idle(output logic [31:0] d);
      logic [1:0] r;
      int n;
      d = 32'h1;
      for (n = 0; n < 30 && d[0] !== 1'b0; n++) rd(A_CTRL, d, r);
      if (d[0] !== 1'b0) begin
         fail_count++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] r;
      logic [31:0] d;
      logic [8:0] ld;
      int k;
      logic [7:0] bad [6] = '{8'h02, 8'h07, 8'h13, 8'h0b, 8'h1f, 8'h10};
      repeat (3) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd(A_CTRL, d, r);
      chk(d, 32'h0);
      rd(A_STAT, d, r);
      chk(d & 32'h3f, 32'h3f);
      wr(12'h100, 8'hff, r);
      chk(r, 2'b11);
      rd(12'h100, d, r);
      chk(r, 2'b11);
      // other patterns are ignored
      for (k = 0; k < 6; k++) begin
         wr(A_CTRL, bad[k], r);
         rd(A_CTRL, d, r);
         chk(d, 32'h0);
      end
      // ready irq and enable window
      irq_g <= 1'b1;
      wr(A_CTRL, 8'h81, r);
      chk(irq, 1'b0);
      repeat (2) @(posedge sys_clk_i);
      chk(irq, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk(irq, 1'b1);
      irq_g <= 1'b0;
      @(posedge sys_clk_i);
      chk(irq, 1'b0);
      irq_g <= 1'b1;
      // erase in the concurrent section
      wr(A_CTRL, 8'h83, r);
      u_fspc_cpu_model.issue(1'b1, 18'h01000, 16'h0000);
      repeat (2) @(posedge sys_clk_i);
      chk(last_cmd, {1'b1, 1'b0, 10'h010});
      chk({blocked, cpu_rsp.hold, irq}, 3'b100);
      wr(A_CTRL, 8'h91, r);
      rd(A_CTRL, d, r);
      chk(d, 32'hc3);
      wait_idle(d);
      chk(d, 32'hc0);
      // fill a word, busy flag drops
      wr(A_CTRL, 8'h81, r);
      u_fspc_cpu_model.issue(1'b1, 18'h0000a, 16'hbeef);
      repeat (2) @(posedge sys_clk_i);
      chk(blocked, 1'b0);
      buf_chk(7'h05, 16'hbeef);
      wr(A_CTRL, 8'h91, r);
      buf_chk(7'h05, 16'hffff);
      u_fspc_cpu_model.issue(1'b1, 18'h00000, 16'h0000);
      // page write into the non-concurrent section
      wr(A_CTRL, 8'h81, r);
      u_fspc_cpu_model.issue(1'b1, 18'h00000, 16'h1234);
      wr(A_CTRL, 8'h85, r);
      k = op_count;
      u_fspc_cpu_model.issue(1'b1, 18'h3e000, 16'h0000);
      repeat (2) @(posedge sys_clk_i);
      chk(last_cmd, {1'b0, 1'b1, 10'h3e0});
      chk({blocked, cpu_rsp.hold}, 2'b01);
      wait_idle(d);
      buf_chk(7'h00, 16'hffff);
      // lock set and lock/fuse read
      wr(A_CFG, 8'h01, r);
      wr(A_CTRL, 8'h89, r);
      u_fspc_cpu_model.issue(1'b1, 18'h3ffff, 16'h55fb);
      rd(A_STAT, d, r);
      chk(d & 32'h3f, 32'h3b);
      wr(A_CTRL, 8'h89, r);
      u_fspc_cpu_model.load(18'h00000, ld);
      chk(ld, 9'h1fb);
      wr(A_CTRL, 8'h89, r);
      u_fspc_cpu_model.load(18'h00001, ld);
      chk(ld, 9'h1fd);
      // application page refused, boot page accepted
      wr(A_CTRL, 8'h83, r);
      k = op_count;
      u_fspc_cpu_model.issue(1'b1, 18'h3e000, 16'h0000);
      repeat (3) @(posedge sys_clk_i);
      chk(op_count, k);
      wait_idle(d);
      wr(A_CTRL, 8'h83, r);
      u_fspc_cpu_model.issue(1'b1, 18'h3f000, 16'h0000);
      repeat (2) @(posedge sys_clk_i);
      chk(last_cmd, {1'b1, 1'b0, 10'h3f0});
      chk(cpu_rsp.hold, 1'b1);
      wait_idle(d);
      // signature byte one
      wr(A_CTRL, 8'ha1, r);
      u_fspc_cpu_model.load(18'h00002, ld);
      chk(ld, 9'h13c);
      close_out();
   end
endmodule
bind fspc_top fspc_top_properties #(.ERASE_CYCLES(ERASE_CYCLES),
   .WRITE_CYCLES(WRITE_CYCLES)) u_fspc_top_properties (
   .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .bresp_o(bresp_o),
   .bvalid_o(bvalid_o), .bready_i(bready_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .rready_i(rready_i), .cpu_req_i(cpu_req_i),
   .irq_global_i(irq_global_i), .cpu_rsp_o(cpu_rsp_o),
   .prog_ready_irq_o(prog_ready_irq_o),
   .section_blocked_o(section_blocked_o), .flash_cmd_o(flash_cmd_o));
`default_nettype wire
